// [common/bib_pkg.sv]
/*
 * bib_pkg: constants and carrier types for the bus info block register bank.
 * Assumes a 32-bit AXI4-Lite register bus and a single controller clock.
 */
package bib_pkg;

    // register byte offsets
    localparam logic [7:0]  OFS_ROM_HEADER   = 8'h18;
    localparam logic [7:0]  OFS_BUS_NAME     = 8'h1c;
    localparam logic [7:0]  OFS_NODE_OPTIONS = 8'h20;
    localparam logic [7:0]  OFS_CTRL         = 8'h28;
    localparam int          ADDR_W           = 8;

    // header fields
    localparam int          HDR_CRC_LSB      = 0;
    localparam int          HDR_CRC_W        = 16;

    // constant read by the identification register
    localparam logic [31:0] BUS_NAME_VALUE   = 32'h31333934;

    // options field positions
    localparam int          OPT_IRMC         = 31;
    localparam int          OPT_CMC          = 30;
    localparam int          OPT_ISC          = 29;
    localparam int          OPT_BMC          = 28;
    localparam int          OPT_PMC          = 27;
    localparam int          OPT_ACC_LSB      = 16;
    localparam int          OPT_MAXREC_LSB   = 12;
    localparam int          OPT_GEN_LSB      = 6;
    localparam int          OPT_SPD_LSB      = 0;

    // writable bits of the options word; the rest read fixed
    localparam logic [31:0] OPT_RW_MASK      = 32'hf8fff0c0;
    localparam logic [3:0]  MAXREC_RESET     = 4'hb;
    localparam logic [2:0]  LINK_SPEED       = 3'h3;
    localparam logic [31:0] OPT_FIXED        = 32'h00000003;

    // control register: bit 0 link_on
    localparam int          CTRL_LINK_ON     = 0;

    // axi response codes
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } bib_wreq_s;

    typedef struct packed {
        logic [31:0] rom_header;
        logic [31:0] bus_name;
        logic [31:0] node_options;
    } bib_quads_s;

endpackage

// [hw/bib_merge.sv]
/*
 * bib_merge: applies byte strobes to a register word under a writable mask.
 * Pure combinational; used by the register bank for every writable register.
 */
`timescale 1ns/1ps
module bib_merge (
    input  wire logic [31:0] old_val,
    input  wire logic [31:0] wr_val,
    input  wire logic [3:0]  strb,
    input  wire logic [31:0] rw_mask,
    output logic      [31:0] new_val
);
    logic [31:0] lane_mask;

    // expand strobes, then keep read-only bits untouched
    always_comb begin
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        new_val   = (old_val & ~(lane_mask & rw_mask)) | (wr_val & lane_mask & rw_mask);
    end
endmodule

// [hw/bib_regs.sv]
/*
 * bib_regs: bus info block register bank behind an AXI4-Lite slave.
 * Holds the ROM header, bus name constant, node options and a link control
 * word. Assumes one clock, synchronous active-low reset, and that the link
 * layer reads configuration ROM quadlets through the rom port.
 */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps

module bib_regs
    import bib_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              soft_reset,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rom_rd,
    input  wire logic [1:0]        rom_idx,
    output logic                   rom_valid,
    output logic      [31:0]       rom_data,
    output logic                   link_on
);
    typedef struct packed {
        logic        aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [31:0] rom_header;
        logic [31:0] options;
        logic        link_on;
    } bib_state_s;

    bib_state_s  st_r;
    bib_state_s  st_nxt;
    bib_quads_s  quads;
    logic [31:0] hdr_merged;
    logic [31:0] opt_merged;
    logic [31:0] ctl_merged;
    logic        do_write;

    // known offsets for both decode paths
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_ROM_HEADER) || (a == OFS_BUS_NAME) ||
               (a == OFS_NODE_OPTIONS) || (a == OFS_CTRL);
    endfunction

    // options word as read: writable bits plus fixed link speed
    function automatic logic [31:0] opt_view(input logic [31:0] v);
        return (v & OPT_RW_MASK) | OPT_FIXED;
    endfunction

    assign quads.rom_header   = st_r.rom_header;
    assign quads.bus_name     = BUS_NAME_VALUE;
    assign quads.node_options = opt_view(st_r.options);

    // one merge per writable register keeps strobe handling in one place
    bib_merge u_hdr_merge (
        .old_val (st_r.rom_header),
        .wr_val  (st_r.w_data),
        .strb    (st_r.w_strb),
        .rw_mask (32'hffffffff),
        .new_val (hdr_merged)
    );

    bib_merge u_opt_merge (
        .old_val (st_r.options),
        .wr_val  (st_r.w_data),
        .strb    (st_r.w_strb),
        .rw_mask (OPT_RW_MASK),
        .new_val (opt_merged)
    );

    bib_merge u_ctl_merge (
        .old_val ({31'h0, st_r.link_on}),
        .wr_val  (st_r.w_data),
        .strb    (st_r.w_strb),
        .rw_mask (32'h00000001),
        .new_val (ctl_merged)
    );

    bib_rom_port u_rom_port (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .quads     (quads),
        .rom_rd    (rom_rd),
        .rom_idx   (rom_idx),
        .rom_valid (rom_valid),
        .rom_data  (rom_data)
    );

    // write fires once address and data are both held and no response waits
    assign do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;

    always_comb begin
        st_nxt = st_r;
        // address and data taken independently, in either order
        if (s_axi_awvalid && !st_r.aw_held) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_held) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = is_mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_r.aw_addr)
                OFS_ROM_HEADER:   st_nxt.rom_header = hdr_merged;
                OFS_NODE_OPTIONS: st_nxt.options    = opt_merged;
                OFS_CTRL:         st_nxt.link_on    = ctl_merged[CTRL_LINK_ON];
                default:          ;  // bus name write dropped
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // read: answer one cycle after the address is taken
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFS_ROM_HEADER:   st_nxt.rdata = st_r.rom_header;
                OFS_BUS_NAME:     st_nxt.rdata = BUS_NAME_VALUE;
                OFS_NODE_OPTIONS: st_nxt.rdata = opt_view(st_r.options);
                OFS_CTRL:         st_nxt.rdata = {31'h0, st_r.link_on};
                default:          st_nxt.rdata = 32'h00000000;
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        // soft reset leaves max request alone, clears the rest of options
        if (soft_reset) begin
            st_nxt.options = st_nxt.options &
                             (32'h0000000f << OPT_MAXREC_LSB);
            st_nxt.link_on = 1'b0;
        end
    end

    // crc value and generation bits keep their current value through reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.aw_held    <= 1'b0;
            st_r.aw_addr    <= '0;
            st_r.w_held     <= 1'b0;
            st_r.w_data     <= 32'h00000000;
            st_r.w_strb     <= 4'h0;
            st_r.bvalid     <= 1'b0;
            st_r.bresp      <= RESP_OKAY;
            st_r.rvalid     <= 1'b0;
            st_r.rresp      <= RESP_OKAY;
            st_r.rdata      <= 32'h00000000;
            st_r.rom_header <= {16'h0000, st_nxt.rom_header[15:0]};
            st_r.options    <= {16'h0000, MAXREC_RESET, 4'h0,
                                st_nxt.options[7:6], 6'h00};
            st_r.link_on    <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = !st_r.aw_held;
    assign s_axi_wready  = !st_r.w_held;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rdata   = st_r.rdata;
    assign link_on       = st_r.link_on;  // software keeps fields valid
endmodule

// [hw/bib_rom_port.sv]
/*
 * bib_rom_port: answers remote configuration ROM quadlet reads from the
 * register values. Assumes the link side issues one-cycle read strobes.
 */
`timescale 1ns/1ps
module bib_rom_port
    import bib_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire bib_quads_s  quads,
    input  wire logic        rom_rd,
    input  wire logic [1:0]  rom_idx,
    output logic             rom_valid,
    output logic      [31:0] rom_data
);
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } bib_rport_s;

    bib_rport_s st_r;
    bib_rport_s st_nxt;

    // quadlet 0 header, 1 bus name, 2 options
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = rom_rd;
        if (rom_rd) begin
            unique case (rom_idx)
                2'h0:    st_nxt.data = quads.rom_header;
                2'h1:    st_nxt.data = quads.bus_name;
                2'h2:    st_nxt.data = quads.node_options;
                default: st_nxt.data = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rom_valid = st_r.valid;
    assign rom_data  = st_r.data;
endmodule

// [tb/bib_regs_asserts.sv]
/* bib_regs_asserts: timing and content checks on the bib_regs ports.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module bib_regs_asserts
    import bib_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        rom_rd,
    input wire logic [1:0]  rom_idx,
    input wire logic        rom_valid,
    input wire logic [31:0] rom_data,
    input wire logic        soft_reset,
    input wire logic        link_on
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read address taken at a given offset
    sequence s_ar(logic [7:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    property p_rom_lat; rom_rd |=> rom_valid; endproperty
    property p_rom_name; rom_rd && rom_idx == 2'h1 |=> rom_data == BUS_NAME_VALUE; endproperty
    property p_rom_fix; rom_rd && rom_idx == 2'h2 |=> (rom_data & ~OPT_RW_MASK) == OPT_FIXED;
    endproperty
    property p_rd_name; s_ar(OFS_BUS_NAME) |=> s_axi_rvalid && s_axi_rdata == BUS_NAME_VALUE;
    endproperty
    property p_rd_fix; s_ar(OFS_NODE_OPTIONS) |=> (s_axi_rdata & ~OPT_RW_MASK) == OPT_FIXED;
    endproperty
    property p_rd_bad; s_ar(8'h04) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_rd_hdr; s_ar(OFS_ROM_HEADER) |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY;
    endproperty
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    // control read must mirror the link_on pin as it stood when taken
    property p_link_rd; s_ar(OFS_CTRL) |=> s_axi_rdata[CTRL_LINK_ON] == $past(link_on);
    endproperty
    property p_link_soft; soft_reset |=> !link_on; endproperty
    a_rom_lat: assert property (p_rom_lat) else $error("rom answer late");
    a_rom_name: assert property (p_rom_name) else $error("rom bus name wrong");
    a_rom_fix: assert property (p_rom_fix) else $error("rom fixed bits wrong");
    a_rd_name: assert property (p_rd_name) else $error("bus name read wrong");
    a_rd_fix: assert property (p_rd_fix) else $error("options fixed bits wrong");
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
    a_rd_hdr: assert property (p_rd_hdr) else $error("header read late");
    a_r_done: assert property (p_r_done) else $error("read data held too long");
    a_link_rd: assert property (p_link_rd) else $error("control read disagrees with link_on");
    a_link_soft: assert property (p_link_soft) else $error("link_on kept after soft reset");
endmodule
bind bib_regs bib_regs_asserts bib_regs_asserts_inst (.aclk, .aresetn, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rom_rd, .rom_idx, .rom_valid, .rom_data, .soft_reset, .link_on);

// [tb/bib_rom_node.sv]
/* bib_rom_node: remote node that reads configuration ROM quadlets.
   Assumes the bank answers a one-cycle strobe on the next edge. */
`timescale 1ns/1ps
module bib_rom_node (
    input  wire logic       aclk,
    output logic            rom_rd,
    output logic      [1:0] rom_idx
);
    initial begin
        rom_rd = 1'b0;
        rom_idx = 2'h0;
    end
    // one strobe; index scrambled once released
    task automatic fetch(input logic [1:0] i);
        @(posedge aclk);
        rom_rd <= 1'b1;
        rom_idx <= i;
        @(posedge aclk);
        rom_rd <= 1'b0;
        rom_idx <= ~i;
    endtask
endmodule

// [tb/tb_bus_info_block_registers.sv]
/* tb_bus_info_block_registers: self-checking bench for bib_regs.
   Assumes bib_pkg, the rom node model and the checker compiled first. */
`timescale 1ns/1ps
module tb_bus_info_block_registers;
    import bib_pkg::*;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0]  r;
    } bib_exp_s;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        soft_reset = 1'b0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, v, rdata, rom_data;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rom_rd, rom_valid, link_on;
    logic [1:0]  bresp, rresp, rom_idx;
    bib_exp_s    bq[$], rq[$], mq[$];
    int          err_total = 0, compares = 0, seed = 22, cyc = 0;
    always #50 aclk = ~aclk;
    bib_regs bib_regs_inst (.aclk, .aresetn, .soft_reset, .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .rom_rd,
        .rom_idx, .rom_valid, .rom_data, .link_on);
    bib_rom_node bib_rom_node_inst (.aclk, .rom_rd, .rom_idx);
    task automatic stop_test;
        $display("counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input bib_exp_s e, input logic [31:0] d, input logic [1:0] r);
        compares++;
        if (((d & e.m) !== (e.d & e.m)) || (r !== e.r)) begin
            err_total++;
            $display("BAD t=%0t got %h/%0h want %h/%0h", $time, d, r, e.d, e.r);
        end
    endtask
    // results meet the oldest note of their kind; also the hang limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (bvalid && aresetn) chk(bq.pop_front(), 32'h0, bresp);
        if (rvalid && aresetn) chk(rq.pop_front(), rdata, rresp);
        if (rom_valid && aresetn) chk(mq.pop_front(), rom_data, 2'h0);
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    // ready sampled mid-cycle, where it has settled; bready held high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic ha, hw, hb;
        bq.push_back('{32'h0, 32'h0, r});
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ha = awready;
            hw = wready;
            hb = bvalid;
            @(posedge aclk);
            if (ha && awvalid) awvalid <= 1'b0;
            if (hw && wvalid) wvalid <= 1'b0;
        end while (!hb);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        logic ha, hb;
        rq.push_back('{d, m, r});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ha = arready;
            hb = rvalid;
            @(posedge aclk);
            if (ha && arvalid) arvalid <= 1'b0;
        end while (!hb);
    endtask
    task automatic rom(input logic [1:0] i, input logic [31:0] d);
        mq.push_back('{d, '1, 2'h0});
        bib_rom_node_inst.fetch(i);
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_ROM_HEADER, 32'h0, 32'hffff0000, RESP_OKAY);
        rd(OFS_BUS_NAME, 32'h31333934, '1, RESP_OKAY);
        rd(OFS_NODE_OPTIONS, 32'h0000b003, 32'hffffff3f, RESP_OKAY);
        rd(8'h04, 32'h0, '1, RESP_SLVERR);
        $display("test reset values done");
        v = $random(seed);
        wr(OFS_ROM_HEADER, v, 4'hf, RESP_OKAY);
        wr(OFS_ROM_HEADER, ~v, 4'h4, RESP_OKAY);
        v[23:16] = ~v[23:16];
        rd(OFS_ROM_HEADER, v, '1, RESP_OKAY);
        rom(2'h0, v);
        rom(2'h1, 32'h31333934);
        rom(2'h3, 32'h0);
        $display("test header done");
        wr(OFS_BUS_NAME, 32'h0, 4'hf, RESP_OKAY);
        rd(OFS_BUS_NAME, 32'h31333934, '1, RESP_OKAY);
        wr(OFS_NODE_OPTIONS, '1, 4'hf, RESP_OKAY);
        rd(OFS_NODE_OPTIONS, 32'hf8fff0c3, '1, RESP_OKAY);
        rom(2'h2, 32'hf8fff0c3);
        wr(OFS_CTRL, 32'h1, 4'hf, RESP_OKAY); // fields set first
        rd(OFS_CTRL, 32'h1, '1, RESP_OKAY);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        rd(OFS_NODE_OPTIONS, 32'h0000f003, 32'hffffff3f, RESP_OKAY);
        rd(OFS_CTRL, 32'h0, '1, RESP_OKAY);
        $display("test read-only and soft reset done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_NODE_OPTIONS, 32'h0000b003, 32'hffffff3f, RESP_OKAY);
        rd(OFS_ROM_HEADER, 32'h0, 32'hffff0000, RESP_OKAY);
        for (int i = 28; i < 32; i++) begin
            wr(OFS_NODE_OPTIONS, 32'h1 << i, 4'hf, RESP_OKAY);
            rom(2'h2, (32'h1 << i) | 32'h3);
        end
        $display("test capability flags done");
        repeat (4) @(posedge aclk);
        stop_test();
    end
endmodule
